/* File: dsau_mem_model.sv */
/*
  Far-side model of the register region and the program memory.
  Assumes the unit enables a read one cycle before it samples data.
*/
`timescale 1ns/1ns
module dsau_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        sfr_rd_en,
  input  wire logic [10:0] sfr_rd_addr,
  input  wire logic        pgm_rd_en,
  input  wire logic [23:0] pgm_addr,
  output logic             sfr_hit,
  output logic [15:0]      sfr_rdata,
  output logic [15:0]      pgm_rdata
);
  // Outputs start at known levels.
  initial begin
    sfr_hit   = 1'b0;
    sfr_rdata = 16'h0000;
    pgm_rdata = 16'h0000;
  end

  // Answers one cycle after an enable; idle lines show the inverse.
  always @(posedge clk_sys) begin
    if (sfr_rd_en) begin
      sfr_hit   <= ~sfr_rd_addr[5];
      sfr_rdata <= {5'h15, sfr_rd_addr};
    end else begin
      sfr_hit   <= ~sfr_hit;
      sfr_rdata <= ~sfr_rdata;
    end
    if (pgm_rd_en) begin
      pgm_rdata <= pgm_addr[15:0] ^ 16'hc3c3;
    end else begin
      pgm_rdata <= ~pgm_rdata;
    end
  end
endmodule

/* File: dsau_pgm.sv */
/*
  Program space address former. Builds the 24-bit program address from
  the fetch counter, a table operation or a window read from data space
  and flags whether it leaves the user half. Purely combinational.
  Assumes at most one of the table and window requests wins a cycle.
*/
`timescale 1ns/1ns
module dsau_pgm
  import dsau_pkg::*;
(
  input  wire logic [PC_W-1:0]   fetch_pc,
  input  wire logic              tbl_req,
  input  wire logic [EA_W-1:0]   tbl_ea,
  input  wire logic [PAGE_W-1:0] table_page_reg,
  input  wire logic              psv_req,
  input  wire logic [EA_W-2:0]   psv_off,
  input  wire logic [PAGE_W-1:0] psv_page,
  output logic [PGM_AW-1:0]      pgm_addr,
  output logic                   pgm_cfg_sel,
  output logic                   pgm_user_ok
);

  // Window reads win over table operations, which win over fetch.
  always_comb begin
    if (psv_req) begin
      pgm_addr = {1'b0, psv_page, psv_off};
    end else if (tbl_req) begin
      pgm_addr = {table_page_reg, tbl_ea};
    end else begin
      pgm_addr = {1'b0, fetch_pc};
    end
  end

  // Only the table page bit opens the upper half to a table access.
  assign pgm_cfg_sel = tbl_req && !psv_req &&
                       table_page_reg[CFG_BIT];
  assign pgm_user_ok = (pgm_addr <= PGM_USER_LAST);

endmodule

/* File: dsau_pkg.sv */
/*
  Shared constants and types of the data space access unit: address
  widths, region limits, byte lane codes and the request carriers.
  Assumes it is compiled before every module of the unit.
*/
package dsau_pkg;

  // Address widths of the data and program spaces.
  localparam int unsigned EA_W      = 16;
  localparam int unsigned PC_W      = 23;
  localparam int unsigned PGM_AW    = 24;
  localparam int unsigned PAGE_W    = 8;
  localparam int unsigned NEAR_W    = 13;
  localparam int unsigned CFG_BIT   = 7;

  // Data space regions, as byte addresses.
  localparam logic [15:0] SFR_LAST      = 16'h07FF;
  localparam logic [15:0] NEAR_LAST     = 16'h1FFF;
  localparam logic [15:0] RAM_BASE_DEF  = 16'h0800;
  localparam int unsigned RAM_BYTES_DEF = 2048;

  // Highest program address open to ordinary user accesses.
  localparam logic [23:0] PGM_USER_LAST = 24'h7F_FFFF;

  // Byte lane strobes and post-increment steps.
  localparam logic [1:0]  LANE_LO   = 2'h1;
  localparam logic [1:0]  LANE_HI   = 2'h2;
  localparam logic [1:0]  LANE_WORD = 2'h3;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // Cycles from a read request to its answer.
  localparam int unsigned RD_LATENCY = 2;

  // One data access as issued by a read or write address generator.
  typedef struct packed {
    logic        byte_op;
    logic        near_mode;
    logic [15:0] ea;
  } dsau_acc_t;

  // Region that a data read resolved to.
  typedef enum logic [1:0] {
    DSAU_REG_NONE = 2'h0,
    DSAU_REG_SFR  = 2'h1,
    DSAU_REG_RAM  = 2'h3,
    DSAU_REG_PSV  = 2'h2
  } dsau_region_t;

  // Working register operations.
  typedef enum logic [2:0] {
    DSAU_WOP_LOADB = 3'h0,
    DSAU_WOP_SEXT  = 3'h1,
    DSAU_WOP_ZEXT  = 3'h3,
    DSAU_WOP_PINC  = 3'h2
  } dsau_wop_t;

endpackage

/* File: dsau_ram.sv */
/*
  Data RAM as two byte-wide lanes with a shared word decode and one
  write strobe per lane. One synchronous read port, one write port.
  Assumes indices in range; a read and a write to one word in the
  same cycle return the old contents.
*/
`timescale 1ns/1ns
module dsau_ram
  import dsau_pkg::*;
#(
  parameter int unsigned WORDS = RAM_BYTES_DEF / 2,
  parameter int unsigned IDX_W = $clog2(WORDS)
) (
  input  wire logic             clk_sys,
  input  wire logic             rd_en,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [15:0]      rd_data_q,
  input  wire logic [1:0]       wr_lane,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [15:0]      wr_data
);

  if (WORDS < 2 || (1 << IDX_W) != WORDS) begin : g_chk
    $error("dsau_ram: WORDS must be a power of two of at least two");
  end

  // Each lane keeps its own array and write strobe.
  for (genvar l = 0; l < 2; l++) begin : g_lane
    logic [7:0] mem [WORDS];
    logic [7:0] rd_byte_q;
    always_ff @(posedge clk_sys) begin
      if (wr_lane[l]) begin
        mem[wr_idx] <= wr_data[8*l +: 8];
      end
    end
    always_ff @(posedge clk_sys) begin
      if (rd_en) begin
        rd_byte_q <= mem[rd_idx];
      end
    end
    // Each lane owns its half of the read word, so one driver per bit.
    assign rd_data_q[8*l +: 8] = rd_byte_q;
  end

endmodule

/* File: dsau_top.sv */
/*
  Data space access unit: decodes read and write effective addresses
  into the register region, data RAM and program window, selects byte
  lanes, checks word alignment and raises the address error trap, and
  performs the byte-related working register operations.
  Assumes the register region and the program memory answer a read
  one cycle after their enable, with data held for that cycle.
*/
// Behaviour
// - Program space is 4M words, 24-bit address from counter, table or window.
// - Ordinary user program accesses stay within the lower half of space.
// - Table operations reach configuration space only via table page bit 7.
// - Data effective addresses are 16-bit byte pointers over 64 Kbytes.
// - Top bit clear goes to memory; top bit set goes to program window.
// - Up to 2 Kbytes RAM; reads elsewhere return zero.
// - Low byte sits at even address, high byte at next odd address.
// - Post-increment adds one for byte and two for word operations.
// - Byte read fetches whole word, picks byte by bit 0, returns low.
// - Two byte lanes share decode; byte writes strobe only their lane.
// - Word access at odd address raises the address error trap.
// - Misaligned read completes; misaligned write is suppressed; trap follows.
// - Byte loads into a working register keep its high byte.
// - Sign-extend widens 8 to 16 bits; zero-extend clears high byte.
// - Bytes 0x0000 to 0x07FF decode as the register region.
// - Unused register region addresses read as zero.
// - Bytes 0x0000 to 0x1FFF are near space via a 13-bit field.
// - Whole data space reachable by 16-bit direct or register pointer.
// - Read and write addresses come from separate, independent generators.
`timescale 1ns/1ns
module dsau_top
  import dsau_pkg::*;
#(
  parameter logic [15:0] RAM_BASE  = RAM_BASE_DEF,
  parameter int unsigned RAM_BYTES = RAM_BYTES_DEF
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              rd_req,
  input  wire dsau_acc_t         rd_cmd,
  output logic                   rd_valid_q,
  output logic [15:0]            rd_data_q,
  input  wire logic              wr_req,
  input  wire dsau_acc_t         wr_cmd,
  input  wire logic [15:0]       wr_data,
  output logic                   addr_err_q,
  output logic                   addr_err_wr_q,
  output logic                   sfr_rd_en,
  output logic [10:0]            sfr_rd_addr,
  input  wire logic              sfr_hit,
  input  wire logic [15:0]       sfr_rdata,
  output logic [1:0]             sfr_wr_lane,
  output logic [10:0]            sfr_wr_addr,
  output logic [15:0]            sfr_wdata,
  input  wire logic [PC_W-1:0]   fetch_pc,
  input  wire logic              tbl_req,
  input  wire logic [EA_W-1:0]   tbl_ea,
  input  wire logic [PAGE_W-1:0] table_page_reg,
  input  wire logic [PAGE_W-1:0] psv_page,
  output logic                   pgm_rd_en,
  output logic [PGM_AW-1:0]      pgm_addr,
  output logic                   pgm_cfg_sel,
  output logic                   pgm_user_ok,
  input  wire logic [15:0]       pgm_rdata,
  input  wire logic              wop_valid,
  input  wire dsau_wop_t         wop,
  input  wire logic              wop_byte,
  input  wire logic [15:0]       wop_reg,
  input  wire logic [7:0]        wop_data,
  output logic                   wop_done_q,
  output logic [15:0]            wop_result_q
);

  localparam int unsigned WORDS = RAM_BYTES / 2;
  localparam int unsigned IDX_W = $clog2(WORDS);
  localparam logic [16:0] RAM_END = 17'(RAM_BASE) + 17'(RAM_BYTES);

  if (RAM_BYTES < 4 || (1 << $clog2(RAM_BYTES)) != RAM_BYTES ||
      RAM_BASE <= SFR_LAST || RAM_END > 17'h0_8000 ||
      RAM_BASE[0]) begin : g_chk
    $error("dsau_top: RAM must be a power of two inside 0x0800..0x7FFF");
  end

  // Effective address, with near mode taking only the 13-bit field.
  function automatic logic [15:0] eff_ea(input dsau_acc_t a);
    if (a.near_mode) begin
      return {3'h0, a.ea[NEAR_W-1:0]};
    end
    return a.ea;
  endfunction

  // Region of a data effective address.
  function automatic dsau_region_t region_of(input logic [15:0] ea);
    if (ea[15]) begin
      return DSAU_REG_PSV;
    end
    if (ea <= SFR_LAST) begin
      return DSAU_REG_SFR;
    end
    if (17'(ea) >= 17'(RAM_BASE) && 17'(ea) < RAM_END) begin
      return DSAU_REG_RAM;
    end
    return DSAU_REG_NONE;
  endfunction

  logic [15:0]      rd_ea;
  logic [15:0]      wr_ea;
  dsau_region_t     rd_reg;
  dsau_region_t     wr_reg;
  logic             rd_mis;
  logic             wr_mis;
  logic [1:0]       wr_lane;
  logic [1:0]       ram_lane;
  logic [15:0]      wr_word;
  logic [15:0]      rd_base;
  logic [15:0]      wr_base;
  logic [IDX_W-1:0] rd_idx;
  logic [IDX_W-1:0] wr_idx;
  logic [15:0]      ram_rdata;
  logic [15:0]      src_word;
  logic [7:0]       sel_byte;

  // Decode both generators' addresses independently of each other.
  assign rd_ea  = eff_ea(rd_cmd);
  assign wr_ea  = eff_ea(wr_cmd);
  assign rd_reg = region_of(rd_ea);
  assign wr_reg = region_of(wr_ea);

  // Only word accesses are checked, and only on address bit 0.
  assign rd_mis = rd_req && !rd_cmd.byte_op && rd_ea[0];
  assign wr_mis = wr_req && !wr_cmd.byte_op && wr_ea[0];

  // Byte writes strobe the lane picked by bit 0; aligned word writes both, misaligned ones neither.
  always_comb begin
    if (!wr_req || wr_mis) begin
      wr_lane = 2'h0;
    end else if (wr_cmd.byte_op) begin
      wr_lane = wr_ea[0] ? LANE_HI : LANE_LO;
    end else begin
      wr_lane = LANE_WORD;
    end
  end

  // A byte is presented on both lanes so either strobe stores it.
  assign wr_word = wr_cmd.byte_op ? {wr_data[7:0], wr_data[7:0]} : wr_data;

  // Word indices inside the RAM, relative to its base.
  assign rd_base = rd_ea - RAM_BASE;
  assign wr_base = wr_ea - RAM_BASE;
  assign rd_idx  = rd_base[IDX_W:1];
  assign wr_idx  = wr_base[IDX_W:1];
  assign ram_lane = (wr_reg == DSAU_REG_RAM) ? wr_lane : 2'h0;

  dsau_ram #(
    .WORDS (WORDS)
  ) u_ram (
    .clk_sys   (clk_sys),
    .rd_en     (rd_req && rd_reg == DSAU_REG_RAM),
    .rd_idx    (rd_idx),
    .rd_data_q (ram_rdata),
    .wr_lane   (ram_lane),
    .wr_idx    (wr_idx),
    .wr_data   (wr_word)
  );

  // Register region strobes; word address ignores bit 0.
  assign sfr_rd_en   = rd_req && rd_reg == DSAU_REG_SFR;
  assign sfr_rd_addr = {rd_ea[10:1], 1'b0};
  assign sfr_wr_lane = (wr_reg == DSAU_REG_SFR) ? wr_lane : 2'h0;
  assign sfr_wr_addr = {wr_ea[10:1], 1'b0};
  assign sfr_wdata   = wr_word;

  // Program address former shared by fetch, table and window reads.
  dsau_pgm u_pgm (
    .fetch_pc       (fetch_pc),
    .tbl_req        (tbl_req),
    .tbl_ea         (tbl_ea),
    .table_page_reg (table_page_reg),
    .psv_req        (pgm_rd_en),
    .psv_off        ({rd_ea[14:1], 1'b0}),
    .psv_page       (psv_page),
    .pgm_addr       (pgm_addr),
    .pgm_cfg_sel    (pgm_cfg_sel),
    .pgm_user_ok    (pgm_user_ok)
  );
  assign pgm_rd_en = rd_req && rd_reg == DSAU_REG_PSV;

  // First read stage: remember where the word comes from.
  dsau_region_t s1_reg_q;
  logic         s1_valid_q;
  logic         s1_byte_q;
  logic         s1_odd_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1_valid_q <= 1'b0;
      s1_reg_q   <= DSAU_REG_NONE;
      s1_byte_q  <= 1'b0;
      s1_odd_q   <= 1'b0;
    end else begin
      s1_valid_q <= rd_req;
      s1_reg_q   <= rd_reg;
      s1_byte_q  <= rd_cmd.byte_op;
      s1_odd_q   <= rd_ea[0];
    end
  end

  // Source word; unmapped places and register misses give zero.
  always_comb begin
    unique case (s1_reg_q)
      DSAU_REG_RAM:  src_word = ram_rdata;
      DSAU_REG_SFR:  src_word = sfr_hit ? sfr_rdata : 16'h0000;
      DSAU_REG_PSV:  src_word = pgm_rdata;
      DSAU_REG_NONE: src_word = 16'h0000;
    endcase
  end

  // Byte reads pick a byte of the full word and return it low.
  assign sel_byte = s1_odd_q ? src_word[15:8] : src_word[7:0];

  // Second read stage: the answer, registered.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 16'h0000;
    end else begin
      rd_valid_q <= s1_valid_q;
      if (s1_valid_q) begin
        rd_data_q <= s1_byte_q ? {8'h00, sel_byte} : src_word;
      end
    end
  end

  // Trap pulse one cycle after a misaligned request of either kind.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_err_q    <= 1'b0;
      addr_err_wr_q <= 1'b0;
    end else begin
      addr_err_q    <= rd_mis || wr_mis;
      addr_err_wr_q <= wr_mis;
    end
  end

  // Working register operations on byte data.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wop_done_q   <= 1'b0;
      wop_result_q <= 16'h0000;
    end else begin
      wop_done_q <= wop_valid;
      if (wop_valid) begin
        unique case (wop)
          DSAU_WOP_LOADB: wop_result_q <= {wop_reg[15:8], wop_data};
          DSAU_WOP_SEXT:  wop_result_q <= {{8{wop_reg[7]}}, wop_reg[7:0]};
          DSAU_WOP_ZEXT:  wop_result_q <= {8'h00, wop_reg[7:0]};
          DSAU_WOP_PINC:  wop_result_q <= wop_reg +
                                (wop_byte ? BYTE_STEP : WORD_STEP);
          default:        wop_result_q <= wop_result_q;
        endcase
      end
    end
  end

  // Checks on the unit's own outputs.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  AST_RD_ANSWER: assert property (
    rd_req |-> ##2 rd_valid_q)
    else $error("read answer not two cycles after request");

  AST_MIS_TRAP: assert property (
    rd_req && !rd_cmd.byte_op && rd_ea[0] |=> addr_err_q)
    else $error("misaligned word read did not trap");

  AST_BYTE_NO_TRAP: assert property (
    (!rd_req || rd_cmd.byte_op) && (!wr_req || wr_cmd.byte_op)
    |=> !addr_err_q)
    else $error("trap raised without a misaligned word access");

  AST_WR_SUPPRESS: assert property (
    wr_req && !wr_cmd.byte_op && wr_ea[0]
    |-> ram_lane == 2'h0 && sfr_wr_lane == 2'h0 ##1 addr_err_wr_q)
    else $error("misaligned write not suppressed or not trapped");

  AST_MIS_RD_DONE: assert property (
    rd_mis |=> addr_err_q ##1 rd_valid_q)
    else $error("misaligned read did not complete");

  AST_BYTE_LOW: assert property (
    rd_req && rd_cmd.byte_op |-> ##2 rd_data_q[15:8] == 8'h00)
    else $error("byte read high byte not zero");

  AST_GAP_ZERO: assert property (
    rd_req && region_of(eff_ea(rd_cmd)) == DSAU_REG_NONE
    |-> ##2 rd_data_q == 16'h0000)
    else $error("unimplemented read returned nonzero data");

  AST_SFR_MISS: assert property (
    s1_valid_q && s1_reg_q == DSAU_REG_SFR && !sfr_hit
    |=> rd_data_q == 16'h0000)
    else $error("unused register address read nonzero");

  AST_PSV_ROUTE: assert property (
    rd_req && rd_ea[15] |-> pgm_rd_en && !pgm_addr[23] &&
    !sfr_rd_en)
    else $error("upper half read not routed to program window");

  AST_BYTE_LANE: assert property (
    wr_req && wr_cmd.byte_op && wr_reg == DSAU_REG_SFR
    |-> sfr_wr_lane == (wr_ea[0] ? LANE_HI : LANE_LO))
    else $error("byte write strobed the wrong lane");

  AST_CFG_GATE: assert property (
    pgm_addr[23] |-> tbl_req && table_page_reg[CFG_BIT] && !pgm_user_ok)
    else $error("upper program half reached without table page bit");

  AST_POST_INC: assert property (
    wop_valid && wop == DSAU_WOP_PINC
    |=> wop_result_q == $past(wop_reg) +
        ($past(wop_byte) ? BYTE_STEP : WORD_STEP))
    else $error("post-increment step wrong");

  AST_LOAD_BYTE: assert property (
    wop_valid && wop == DSAU_WOP_LOADB
    |=> wop_result_q[15:8] == $past(wop_reg[15:8]))
    else $error("byte load disturbed the high byte");

  // An aligned word write must reach both byte lanes together.
  AST_WORD_LANES: assert property (
    wr_req && !wr_cmd.byte_op && !wr_ea[0] && wr_reg == DSAU_REG_SFR
    |-> sfr_wr_lane == LANE_WORD)
    else $error("aligned word write did not strobe both lanes");

  // A near access can never land in the program window.
  AST_NEAR_LOW: assert property (
    rd_req && rd_cmd.near_mode |-> !pgm_rd_en && rd_ea[15:13] == 3'h0)
    else $error("near read left the near space");

  COV_BYTE_ODD: cover property (
    rd_req && rd_cmd.byte_op && rd_ea[0] ##2 rd_valid_q);
  COV_WR_TRAP: cover property (wr_mis ##1 addr_err_wr_q);
  COV_PSV_READ: cover property (pgm_rd_en ##2 rd_valid_q);
  COV_RD_WR: cover property (rd_req && wr_req && rd_ea == wr_ea);

endmodule

/* File: testbench.sv */
/*
  Self-checking bench of the data space access unit with random and
  hand-picked accesses. Assumes the unit and the memory model above.
*/
`timescale 1ns/1ns
module testbench
  import dsau_pkg::*;
;
  logic        clk_sys, resetn, rd_req, wr_req, tbl_req, wop_valid;
  logic        wop_byte, rd_valid_q, addr_err_q, addr_err_wr_q;
  logic        sfr_rd_en, sfr_hit, pgm_rd_en, pgm_cfg_sel, pgm_user_ok;
  logic        wop_done_q;
  dsau_acc_t   rd_cmd, wr_cmd;
  dsau_wop_t   wop;
  logic [15:0] wr_data, tbl_ea, wop_reg, rd_data_q, sfr_rdata, sfr_wdata;
  logic [15:0] pgm_rdata, wop_result_q;
  logic [7:0]  table_page_reg, psv_page, wop_data;
  logic [22:0] fetch_pc;
  logic [10:0] sfr_rd_addr, sfr_wr_addr;
  logic [1:0]  sfr_wr_lane;
  logic [23:0] pgm_addr;
  logic [7:0]  mem [2048];
  logic [31:0] r, s;
  int          bad_count, checked, cyc;

  dsau_top uut (.clk_sys, .resetn, .rd_req, .rd_cmd, .rd_valid_q,
    .rd_data_q, .wr_req, .wr_cmd, .wr_data, .addr_err_q, .addr_err_wr_q,
    .sfr_rd_en, .sfr_rd_addr, .sfr_hit, .sfr_rdata, .sfr_wr_lane,
    .sfr_wr_addr, .sfr_wdata, .fetch_pc, .tbl_req, .tbl_ea,
    .table_page_reg, .psv_page, .pgm_rd_en, .pgm_addr, .pgm_cfg_sel,
    .pgm_user_ok, .pgm_rdata, .wop_valid, .wop, .wop_byte, .wop_reg,
    .wop_data, .wop_done_q, .wop_result_q);

  dsau_mem_model mdl (.clk_sys, .sfr_rd_en, .sfr_rd_addr, .sfr_hit,
    .sfr_rdata, .pgm_rd_en, .pgm_addr, .pgm_rdata);

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("timeout after %0d cycles", cyc);
      finish_test();
    end
  end

  task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Expected read data from the region map and the models.
  function automatic logic [15:0] exp_rd(logic bo, logic [15:0] e);
    logic [15:0] w;
    w = 16'h0000;
    if (e[15])
      w = {psv_page[0], e[14:1], 1'b0} ^ 16'hc3c3;
    else if (e < 16'h0800)
      w = e[5] ? 16'h0000 : {5'h15, e[10:1], 1'b0};
    else if (e < 16'h1000)
      w = {mem[{e[10:1], 1'b1}], mem[{e[10:1], 1'b0}]};
    if (bo)
      w = {8'h00, e[0] ? w[15:8] : w[7:0]};
    return w;
  endfunction

  task automatic do_rd(logic bo, logic nm, logic [15:0] ea, logic [7:0] pg);
    logic [15:0] e;
    e = nm ? {3'h0, ea[12:0]} : ea;
    @(posedge clk_sys);
    rd_req   <= 1'b1;
    rd_cmd   <= '{bo, nm, ea};
    psv_page <= pg;
    #1 chk("pgm_rd_en", pgm_rd_en, e[15]);
    chk("sfr_rd_en", sfr_rd_en, e < 16'h0800);
    if (e < 16'h0800)
      chk("sfr_rd_addr", sfr_rd_addr, {e[10:1], 1'b0});
    if (e[15])
      chk("pgm_addr", pgm_addr, {1'b0, pg, e[14:1], 1'b0});
    @(posedge clk_sys);
    rd_req <= 1'b0;
    #1 chk("addr_err_q", addr_err_q, !bo && e[0]);
    @(posedge clk_sys);
    #1 chk("rd_valid_q", rd_valid_q, 1'b1);
    chk("rd_data_q", rd_data_q, exp_rd(bo, e));
  endtask

  task automatic do_wr(logic bo, logic [15:0] ea, logic [15:0] d);
    logic       mis;
    logic       sfr;
    logic [1:0] ln;
    mis = !bo && ea[0];
    sfr = ea < 16'h0800 && !mis;
    ln  = !sfr ? 2'h0 : !bo ? 2'h3 : ea[0] ? 2'h2 : 2'h1;
    @(posedge clk_sys);
    wr_req  <= 1'b1;
    wr_cmd  <= '{bo, 1'b0, ea};
    wr_data <= d;
    #1 chk("sfr_wr_lane", sfr_wr_lane, ln);
    if (sfr) begin
      chk("sfr_wr_addr", sfr_wr_addr, {ea[10:1], 1'b0});
      chk("sfr_wdata", sfr_wdata, bo ? {d[7:0], d[7:0]} : d);
    end
    @(posedge clk_sys);
    wr_req <= 1'b0;
    #1 chk("addr_err_q", addr_err_q, mis);
    chk("addr_err_wr_q", addr_err_wr_q, mis);
    if (!mis && ea >= 16'h0800 && ea < 16'h1000) begin
      mem[ea[10:0]] = d[7:0];
      if (!bo)
        mem[ea[10:0] | 11'h001] = d[15:8];
    end
  endtask

  task automatic do_wop(dsau_wop_t o, logic b, logic [15:0] v, logic [7:0] d);
    logic [15:0] x;
    case (o)
      DSAU_WOP_LOADB: x = {v[15:8], d};
      DSAU_WOP_SEXT:  x = {{8{v[7]}}, v[7:0]};
      DSAU_WOP_ZEXT:  x = {8'h00, v[7:0]};
      default:        x = v + (b ? 16'h0001 : 16'h0002);
    endcase
    @(posedge clk_sys);
    wop_valid <= 1'b1;
    wop       <= o;
    wop_byte  <= b;
    wop_reg   <= v;
    wop_data  <= d;
    @(posedge clk_sys);
    wop_valid <= 1'b0;
    #1 chk("wop_done_q", wop_done_q, 1'b1);
    chk("wop_result_q", wop_result_q, x);
  endtask

  task automatic do_pgm(logic t, logic [7:0] pg, logic [15:0] ea,
                        logic [22:0] pc);
    logic [23:0] a;
    a = t ? {pg, ea} : {1'b0, pc};
    @(posedge clk_sys);
    tbl_req        <= t;
    table_page_reg <= pg;
    tbl_ea         <= ea;
    fetch_pc       <= pc;
    #1 chk("pgm_addr", pgm_addr, a);
    chk("pgm_cfg_sel", pgm_cfg_sel, t && pg[7]);
    chk("pgm_user_ok", pgm_user_ok, !a[23]);
  endtask

  // Main sequence: reset, fill, corners, random traffic.
  initial begin
    {resetn, rd_req, wr_req, tbl_req, wop_valid, wop_byte} = 6'h00;
    rd_cmd = '0;
    wr_cmd = '0;
    wop = DSAU_WOP_LOADB;
    {wr_data, tbl_ea, wop_reg, table_page_reg, psv_page, wop_data} = '0;
    fetch_pc = '0;
    r = $urandom(82612);
    repeat (5) @(posedge clk_sys);
    #1 chk("rd_valid_q", rd_valid_q, 1'b0);
    chk("wop_done_q", wop_done_q, 1'b0);
    @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 1024; i++) begin
      r = $urandom;
      do_wr(1'b0, 16'h0800 + 16'(2 * i), r[15:0]);
    end
    $display("test ram_fill done");
    do_wr(1'b1, 16'h0a01, 16'h00ab);
    do_rd(1'b0, 1'b0, 16'h0a00, 8'h00);
    do_wr(1'b0, 16'h0a01, 16'hffff);
    do_rd(1'b0, 1'b1, 16'hea00, 8'h00);
    do_rd(1'b0, 1'b0, 16'h0fff, 8'h00);
    do_rd(1'b1, 1'b0, 16'h1000, 8'h00);
    // Read and write of one word in one cycle: the read sees old data.
    @(posedge clk_sys);
    rd_req  <= 1'b1;
    rd_cmd  <= '{1'b0, 1'b0, 16'h0a00};
    wr_req  <= 1'b1;
    wr_cmd  <= '{1'b0, 1'b0, 16'h0a00};
    wr_data <= 16'h5a5a;
    @(posedge clk_sys);
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    @(posedge clk_sys);
    #1 chk("rd_data_q", rd_data_q, exp_rd(1'b0, 16'h0a00));
    mem[11'h200] = 8'h5a;
    mem[11'h201] = 8'h5a;
    do_rd(1'b0, 1'b0, 16'h0a00, 8'h00);
    $display("test corners done");
    repeat (400) begin
      r = $urandom;
      s = $urandom;
      if (r[17:16] == 2'h0)
        r[15:11] = 5'h01;
      if (r[17:16] == 2'h1)
        r[15:11] = 5'h00;
      @(posedge clk_sys);
      tbl_req <= s[9];
      if (r[18])
        do_wr(r[19], r[15:0], s[31:16]);
      else
        do_rd(r[19], r[20], r[15:0], s[7:0]);
    end
    $display("test random access done");
    for (int k = 0; k < 4; k++) begin
      repeat (6) begin
        r = $urandom;
        do_wop(dsau_wop_t'(k), r[24], r[15:0], r[23:16]);
      end
    end
    $display("test wop done");
    do_pgm(1'b1, 8'h7f, 16'hffff, 23'h00_0000);
    do_pgm(1'b1, 8'h80, 16'h0000, 23'h00_0000);
    do_pgm(1'b0, 8'hff, 16'hffff, 23'h7f_ffff);
    repeat (30) begin
      r = $urandom;
      s = $urandom;
      do_pgm(r[0], r[15:8], s[15:0], s[31:9]);
    end
    $display("test program address done");
    finish_test();
  end
endmodule
